/* File: lane_cfg_status.sv */
// Purpose: per-lane configuration command engine with outcome status fields
// Assumes: classic wishbone slave, one cycle answer, synchronous inputs
// Notes: one engine serves paths in turn; accepted paths wait as pending
`timescale 1ns/1ps
`default_nettype none
`include "lane_cfg_params.svh"

module lane_cfg_status #(
	parameter int          EXEC_CYCLES = 16,
	parameter logic [3:0]  DEFAULT_APP = 4'h1
) (
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      sys_rst,
	// wishbone slave
	input  wire lane_cfg_pkg::wb_req_type  wb_req,
	output var  logic                      wb_ack_o,
	output var  logic [31:0]               wb_dat_o,
	// lane conditions
	input  wire lane_cfg_pkg::lane_env_type lane_env,
	// engine state
	output var  logic                      mgmt_ready,
	output var  logic                      cmd_busy
);
	import lane_cfg_pkg::*;

	// refuse execute counts that the 16-bit countdown cannot hold
	if (EXEC_CYCLES < 1 || EXEC_CYCLES > 65535) begin : g_bad_exec
		$error("EXEC_CYCLES out of range");
	end

	localparam logic [15:0] EXEC_LAST = 16'(EXEC_CYCLES - 1);

	// how a command travels through this block
	//
	// acceptance happens in the bus cycle itself: at the edge where the
	// master sees ack on a trigger write, the target lanes are worked out,
	// checked against the pending mask and, if free, marked pending with
	// the in-progress code in their status nibbles. a copy of the staged
	// lane words is taken at that edge, so the host may rewrite the staged
	// set while the command waits without changing what gets executed.
	//
	// one engine serves the pending lanes, one path at a time. it picks
	// the path of the lowest pending lane, validates the snapshot in one
	// cycle, counts the execute cycles down and then writes the outcome
	// code into every lane of that group in a single edge.
	//
	// the trade-off: a second path accepted while the engine is busy
	// waits for the first to finish instead of running alongside it. this
	// keeps one validator and one countdown, at the price of latency for
	// the later path. hosts see this only as a longer pending time.
	//
	// hazards kept out by construction:
	// - acceptance only marks lanes that are not pending, and feedback only
	//   clears lanes of the group in service, which are pending; the two
	//   can fall in one cycle but never touch the same lane.
	// - the engine group is fixed when it leaves idle, so a fresh trigger
	//   on another path cannot widen the group under validation.
	// - triggers during the startup cycle are ignored, so the default
	//   active set is never overwritten by a command that raced it.
	//
	// limitation: lanes not covered by a staged first-lane field of their
	// own are grouped by whatever that field holds; a host that stages
	// overlapping paths gets the validator's lane-set rejection.

	state_type state_reg;
	state_type state_next;

	// lanes sharing a path with any triggered lane of the given set
	function automatic logic [7:0] expand_paths(input dp_cfg_type [7:0] cfg,
		input logic [7:0] mask);
		logic [7:0] res;
		res = 8'h00;
		for (int j = 0; j < 8; j++) begin
			for (int i = 0; i < 8; i++) begin
				if (mask[i] && cfg[i].first == cfg[j].first)
					res[j] = 1'b1;
			end
		end
		return res;
	endfunction : expand_paths

	// pending lanes belonging to the path of the lowest pending lane;
	// a fixed priority keeps service order predictable for the host
	function automatic logic [7:0] pick_group(input dp_cfg_type [7:0] cfg,
		input logic [7:0] pend);
		logic [7:0] res;
		logic [2:0] head;
		logic       found;
		res = 8'h00;
		head = 3'h0;
		found = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (pend[i] && !found) begin
				head = cfg[i].first;
				found = 1'b1;
			end
		end
		for (int i = 0; i < 8; i++) begin
			if (pend[i] && cfg[i].first == head)
				res[i] = 1'b1;
		end
		return res;
	endfunction : pick_group

	// validation of a path snapshot; first failing check gives the code
	// order of checks:
	//   direction triggers without the capability
	//   path init that leaves a lane of the path untriggered
	//   unused or unsupported application
	//   first-lane field pointing outside the group
	//   explicit signal settings not acceptable
	//   path init on lanes that are not switched off
	function automatic logic [3:0] validate(input state_type s, input lane_env_type env);
		logic [3:0] code;
		logic       init;
		code = `OUTCOME_OK;
		init = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (s.grp[i]) begin
				init = s.kind[i] == `KIND_PATH_INIT;
				if (code == `OUTCOME_OK && (s.kind[i] == `KIND_IMM_TX ||
					s.kind[i] == `KIND_IMM_RX) && !env.one_direction_reconf_capable)
					code = `REJECT_GENERIC;
				if (code == `OUTCOME_OK && init && !s.trig[i])
					code = `REJECT_PARTIAL;
			end
		end
		for (int i = 0; i < 8; i++) begin
			if (s.grp[i] && code == `OUTCOME_OK) begin
				if (s.snap[i].app == `OUTCOME_UNKNOWN || !env.apps_ok[s.snap[i].app])
					code = `REJECT_BAD_APP;
				else if (3'(i) < s.snap[i].first || !s.grp[s.snap[i].first])
					code = `REJECT_BAD_LANES;
				else if (s.snap[i].expl && !env.si_ok[i])
					code = `REJECT_BAD_SI;
				else if (init && !env.path_off[i])
					code = `REJECT_LANES_BUSY;
			end
		end
		// reserved and implementation codes are never produced here
		return code;
	endfunction : validate

	// register words: a nibble pair or four lane configurations
	function automatic logic [31:0] cfg_word(input dp_cfg_type [7:0] cfg, input logic hi);
		return hi ? {cfg[7], cfg[6], cfg[5], cfg[4]} : {cfg[3], cfg[2], cfg[1], cfg[0]};
	endfunction : cfg_word

	function automatic logic [31:0] pair_word(input logic [7:0][3:0] st, input int k);
		return {24'h00_0000, st[2 * k + 1], st[2 * k]};
	endfunction : pair_word

	// next state: bus slave, acceptance, engine
	always_comb begin
		logic [7:0]  mask;
		logic [1:0]  kind;
		logic        set;
		logic        imm;
		logic [7:0]  tgt;
		logic [7:0]  idx;
		logic        wr;
		logic [31:0] rd;
		state_next = state_reg;
		mask = 8'h00;
		kind = `KIND_PATH_INIT;
		set = 1'b0;
		imm = 1'b0;
		tgt = 8'h00;
		idx = wb_req.adr[9:2];
		rd = 32'h0000_0000;
		// one cycle answer, ack dropped after one cycle
		state_next.ack = wb_req.cyc && wb_req.stb && !state_reg.ack;
		// writes take effect at the edge where the master sees ack
		wr = state_reg.ack && wb_req.cyc && wb_req.stb && wb_req.we;

		// read map, word index on the bus:
		//   status nibble pairs, two lanes per word
		//   staged sets 0 and 1, four lane words per bus word
		//   active tx (general) and active rx lane words
		//   engine word: state and pending mask, for debug
		// the trigger word is write only and reads as zero, so a host
		// cannot mistake a stale mask for a busy indication.
		// data is registered with ack and zero otherwise, which keeps
		// the read path free of glitches into the master.
		case (idx)
			`IDX_RESULT_LANES_1_2: rd = pair_word(state_reg.status, 0);
			`IDX_RESULT_LANES_3_4: rd = pair_word(state_reg.status, 1);
			`IDX_RESULT_LANES_5_6: rd = pair_word(state_reg.status, 2);
			`IDX_RESULT_LANES_7_8: rd = pair_word(state_reg.status, 3);
			`IDX_STAGED0_LO:       rd = cfg_word(state_reg.staged[0], 1'b0);
			`IDX_STAGED0_HI:       rd = cfg_word(state_reg.staged[0], 1'b1);
			`IDX_STAGED1_LO:       rd = cfg_word(state_reg.staged[1], 1'b0);
			`IDX_STAGED1_HI:       rd = cfg_word(state_reg.staged[1], 1'b1);
			`IDX_ACTIVE_TX_LO:     rd = cfg_word(state_reg.act_tx, 1'b0);
			`IDX_ACTIVE_TX_HI:     rd = cfg_word(state_reg.act_tx, 1'b1);
			`IDX_ACTIVE_RX_LO:     rd = cfg_word(state_reg.act_rx, 1'b0);
			`IDX_ACTIVE_RX_HI:     rd = cfg_word(state_reg.act_rx, 1'b1);
			`IDX_ENGINE:           rd = {22'h00_0000, state_reg.fsm, state_reg.pend};
			default:               rd = 32'h0000_0000; // unmapped reads as zero
		endcase
		state_next.dat = state_next.ack ? rd : 32'h0000_0000;

		// startup lasts one cycle and loads the default application
		if (state_reg.startup) begin
			state_next.startup = 1'b0;
			for (int i = 0; i < 8; i++) begin
				state_next.act_tx[i] = '{app: DEFAULT_APP, first: 3'h0, expl: 1'b0};
				state_next.act_rx[i] = '{app: DEFAULT_APP, first: 3'h0, expl: 1'b0};
			end
		end

		// engine; its lanes never overlap a fresh acceptance below
		case (state_reg.fsm)
			// wait for pending lanes, then freeze one path as the group
			ENG_IDLE: begin
				if (state_reg.pend != 8'h00) begin
					state_next.grp = pick_group(state_reg.snap, state_reg.pend);
					state_next.fsm = ENG_VALIDATE;
				end
			end
			// one cycle of checks; a rejection skips the countdown
			ENG_VALIDATE: begin
				state_next.result = validate(state_reg, lane_env);
				state_next.cnt = EXEC_LAST;
				if (state_next.result != `OUTCOME_OK)
					state_next.fsm = ENG_FEEDBACK;
				else
					state_next.fsm = ENG_EXECUTE;
			end
			ENG_EXECUTE: begin
				// execution cannot fail once validated
				if (state_reg.cnt == 16'h0000) begin
					for (int i = 0; i < 8; i++) begin
						if (state_reg.grp[i]) begin
							if (state_reg.kind[i] != `KIND_IMM_RX)
								state_next.act_tx[i] = state_reg.snap[i];
							if (state_reg.kind[i] != `KIND_IMM_TX)
								state_next.act_rx[i] = state_reg.snap[i];
						end
					end
					state_next.result = `OUTCOME_OK;
					state_next.fsm = ENG_FEEDBACK;
				end else begin
					state_next.cnt = state_reg.cnt - 16'h0001;
				end
			end
			// outcome lands on all group lanes at once, never one by one
			ENG_FEEDBACK: begin
				for (int i = 0; i < 8; i++) begin
					if (state_reg.grp[i])
						state_next.status[i] = state_reg.result;
				end
				state_next.pend = state_reg.pend & ~state_reg.grp;
				state_next.grp = 8'h00;
				state_next.fsm = ENG_IDLE;
			end
			default: state_next.fsm = ENG_IDLE;
		endcase

		// register writes; staged words honour the byte selects so a host
		// may restage a single lane without touching its neighbours
		if (wr) begin
			for (int s = 0; s < 2; s++) begin
				for (int b = 0; b < 4; b++) begin
					if (wb_req.sel[b] && idx == `IDX_STAGED0_LO + 8'(2 * s))
						state_next.staged[s][b] = wb_req.dat[8 * b +: 8];
					if (wb_req.sel[b] && idx == `IDX_STAGED0_HI + 8'(2 * s))
						state_next.staged[s][b + 4] = wb_req.dat[8 * b +: 8];
				end
			end
			if (idx == `IDX_TRIGGER && wb_req.sel[0] && !state_reg.startup) begin
				mask = wb_req.dat[`TRIG_MASK_LSB +: 8];
				if (wb_req.sel[1]) begin
					kind = wb_req.dat[`TRIG_KIND_LSB +: 2];
					set = wb_req.dat[`TRIG_SET_BIT];
				end
				imm = kind != `KIND_PATH_INIT;
				// subset allowed only for immediate apply on live lanes
				if (imm && (mask & ~lane_env.path_live) == 8'h00)
					tgt = mask;
				else
					tgt = expand_paths(state_reg.staged[set], mask);
				// any pending affected lane drops the whole trigger silently
				if ((tgt & state_reg.pend) == 8'h00) begin
					for (int i = 0; i < 8; i++) begin
						if (tgt[i]) begin
							state_next.status[i] = `OUTCOME_PENDING;
							state_next.snap[i] = state_reg.staged[set][i];
							state_next.kind[i] = kind;
							state_next.trig[i] = mask[i];
							state_next.pend[i] = 1'b1;
						end
					end
				end
			end
		end

		// registered copies of the engine flags for the output pins
		state_next.ready = !state_next.startup;
		state_next.busy = state_next.pend != 8'h00;
	end

	// reset clears every field to zero, the no-status code, except startup, which it sets
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= '0;
			state_reg.startup <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state flops
	assign wb_ack_o = state_reg.ack;
	assign wb_dat_o = state_reg.dat;
	assign mgmt_ready = state_reg.ready;
	assign cmd_busy = state_reg.busy;

endmodule : lane_cfg_status
`default_nettype wire

/* File: lane_cfg_params.svh */
// Purpose: constants for the lane configuration command status block
// Assumes: word index = byte address / 4 on a 32-bit classic Wishbone bus
// Notes: Function
// Function
// - each lane field shows handling state and outcome of latest accepted command
// - each trigger runs acceptance, validation, execution, feedback in order
// - acceptance: no affected lane pending, then mark all path lanes pending
// - any affected lane already pending drops the trigger silently, fields unchanged
// - invalid staged configuration skips execution and reports a rejection code
// - valid configuration is executed and execution never fails
// - feedback overwrites every path lane field with the outcome, replacing pending
// - a lane showing an outcome code lets a new trigger be accepted
// - all triggered lanes of one path receive the same outcome value
// - commands cover whole paths, except immediate apply on live lanes
// - four-bit fields, two per byte, even lane high nibble, odd low
// - code 0h means no status, the initial value of every field
// - code 1h means the last accepted command succeeded
// - codes 2h, 3h, 4h: generic, bad application, bad lane set
// - codes 5h, 6h, 7h: bad signal integrity, lanes busy, partial path
// - codes 8h to Bh stay reserved for other validation failures
// - codes Dh to Fh are implementation rejections, negative outcomes
// - code Ch means pending; triggers for such a lane are ignored
// - the active set gets default application before startup state ends
// - active set updates while executing a valid trigger of set 0 or 1
// - one-direction capable: separate tx/rx triggers, general fields mirror tx
`ifndef LANE_CFG_PARAMS_SVH
`define LANE_CFG_PARAMS_SVH

// register word indices; byte address is four times these
`define IDX_RESULT_LANES_1_2 8'hca
`define IDX_RESULT_LANES_3_4 8'hcb
`define IDX_RESULT_LANES_5_6 8'hcc
`define IDX_RESULT_LANES_7_8 8'hcd
`define IDX_STAGED0_LO       8'h10
`define IDX_STAGED0_HI       8'h11
`define IDX_STAGED1_LO       8'h12
`define IDX_STAGED1_HI       8'h13
`define IDX_TRIGGER          8'h14
`define IDX_ACTIVE_TX_LO     8'h18
`define IDX_ACTIVE_TX_HI     8'h19
`define IDX_ACTIVE_RX_LO     8'h1a
`define IDX_ACTIVE_RX_HI     8'h1b
`define IDX_ENGINE           8'h1c

// trigger word fields
`define TRIG_MASK_LSB 0
`define TRIG_KIND_LSB 8
`define TRIG_SET_BIT  10

// trigger kinds
`define KIND_PATH_INIT 2'h0
`define KIND_IMMEDIATE 2'h1
`define KIND_IMM_TX    2'h2
`define KIND_IMM_RX    2'h3

// outcome codes
`define OUTCOME_UNKNOWN   4'h0
`define OUTCOME_OK        4'h1
`define REJECT_GENERIC    4'h2
`define REJECT_BAD_APP    4'h3
`define REJECT_BAD_LANES  4'h4
`define REJECT_BAD_SI     4'h5
`define REJECT_LANES_BUSY 4'h6
`define REJECT_PARTIAL    4'h7
`define OUTCOME_PENDING   4'hc

`endif

/* File: lane_cfg_pkg.sv */
// Purpose: shared types of the lane configuration command status block
// Assumes: eight lanes
// Notes: constants live in lane_cfg_params.svh
`default_nettype none
package lane_cfg_pkg;

	// one lane of a control set: application, first lane of path, explicit si
	typedef struct packed {
		logic [3:0] app;
		logic [2:0] first;
		logic       expl;
	} dp_cfg_type;

	typedef enum logic [1:0] {
		ENG_IDLE     = 2'b00,
		ENG_VALIDATE = 2'b01,
		ENG_EXECUTE  = 2'b10,
		ENG_FEEDBACK = 2'b11
	} engine_type;

	// classic wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [9:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_type;

	// per-lane conditions, supported applications and the one-direction capability reported by the rest of the module
	typedef struct packed {
		logic [7:0]  path_off;
		logic [7:0]  path_live;
		logic [7:0]  si_ok;
		logic [15:0] apps_ok;
		logic        one_direction_reconf_capable;
	} lane_env_type;

	typedef struct packed {
		engine_type             fsm;
		logic                   startup;
		logic [7:0][3:0]        status;
		dp_cfg_type [1:0][7:0]  staged;
		dp_cfg_type [7:0]       act_tx;
		dp_cfg_type [7:0]       act_rx;
		dp_cfg_type [7:0]       snap;
		logic [7:0][1:0]        kind;
		logic [7:0]             trig;
		logic [7:0]             pend;
		logic [7:0]             grp;
		logic [3:0]             result;
		logic [15:0]            cnt;
		logic                   ack;
		logic [31:0]            dat;
		logic                   ready;
		logic                   busy;
	} state_type;

endpackage : lane_cfg_pkg
`default_nettype wire

/* File: lane_cfg_status_chk.sv */
// Purpose: bus and engine timing checks for lane_cfg_status
// Assumes: one clock domain, status nibbles seen only through bus reads
// Notes: busy bound covers eight paths served in turn
`timescale 1ns/1ps
`default_nettype none
`include "lane_cfg_params.svh"
module lane_cfg_status_chk #(
	parameter int EXEC_CYCLES = 16
) (
	// clock and reset
	input wire logic                     sys_clk,
	input wire logic                     sys_rst,
	// bus and engine
	input wire lane_cfg_pkg::wb_req_type wb_req,
	input wire logic                     wb_ack_o,
	input wire logic [31:0]              wb_dat_o,
	input wire logic                     mgmt_ready,
	input wire logic                     cmd_busy
);
	import lane_cfg_pkg::*;
	localparam int BUSY_MAX = 8 * (EXEC_CYCLES + 4) + 8;
	logic rd_ack;
	logic st_rd;
	logic trig_wr;
	// decoded bus events at the edge where the master sees ack
	assign rd_ack = wb_ack_o && !wb_req.we;
	assign st_rd = rd_ack && wb_req.adr[9:2] >= `IDX_RESULT_LANES_1_2
		&& wb_req.adr[9:2] <= `IDX_RESULT_LANES_7_8;
	assign trig_wr = wb_ack_o && wb_req.we && wb_req.adr[9:2] == `IDX_TRIGGER
		&& wb_req.sel[0] && |wb_req.dat[7:0];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	chk_ack_answers: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	chk_field_width: assert property (st_rd |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("status upper bits set");
	chk_no_reserved: assert property (st_rd |-> wb_dat_o[7:6] != 2'h2 && wb_dat_o[3:2] != 2'h2)
		else $error("reserved status code");
	chk_accept_pends: assert property (trig_wr && mgmt_ready |-> ##[1:2] cmd_busy)
		else $error("trigger not pending");
	chk_pend_stages: assert property ($rose(cmd_busy) |-> cmd_busy[*2])
		else $error("pending too short");
	chk_pend_clears: assert property ($rose(cmd_busy) |-> ##[1:BUSY_MAX] !cmd_busy)
		else $error("pending never cleared");
	chk_startup_ready: assert property ($fell(sys_rst) |-> !mgmt_ready ##1 mgmt_ready)
		else $error("startup timing wrong");
	chk_trig_blank: assert property (rd_ack && wb_req.adr[9:2] == `IDX_TRIGGER |-> wb_dat_o == 0)
		else $error("trigger reads nonzero");
	// main scenarios reached
	cover property ($fell(cmd_busy));
	cover property (trig_wr && cmd_busy);
	cover property (st_rd && wb_dat_o[3:0] == 4'h1);
endmodule : lane_cfg_status_chk

bind lane_cfg_status lane_cfg_status_chk #(.EXEC_CYCLES(EXEC_CYCLES)) chk_u (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
	.wb_dat_o(wb_dat_o), .mgmt_ready(mgmt_ready), .cmd_busy(cmd_busy));
`default_nettype wire

/* File: host_ctrl_model.sv */
// Purpose: host controller model issuing classic wishbone cycles
// Assumes: slave acks every request; no latency is assumed
// Notes: released lines show the inverse so stale values never pass
`timescale 1ns/1ps
`default_nettype none
`include "lane_cfg_params.svh"
module host_ctrl_model (
	// clock
	input  wire logic                     sys_clk,
	// wishbone master side
	output var  lane_cfg_pkg::wb_req_type wb_req,
	input  wire logic                     wb_ack_o,
	input  wire logic [31:0]              wb_dat_o
);
	import lane_cfg_pkg::*;
	int stalls = 0;
	initial wb_req = '0;
	// one cycle, held until ack is seen, bounded against a hang
	task automatic xfer(input logic we, input logic [7:0] idx, input logic [3:0] sel,
		input logic [31:0] wdat, output logic [31:0] rdat);
		int n;
		n = 0;
		@(posedge sys_clk);
		wb_req <= '{1'b1, 1'b1, we, {idx, 2'b00}, sel, wdat};
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 64);
		if (n >= 64) stalls++;
		rdat = wb_dat_o;
		wb_req <= '{1'b0, 1'b0, ~we, ~{idx, 2'b00}, ~sel, ~wdat};
	endtask : xfer
	// lane mask, apply flavour and staged set in one trigger word
	task automatic trigger(input logic [7:0] mask, input logic [1:0] kind, input logic set);
		logic [31:0] d;
		xfer(1'b1, `IDX_TRIGGER, 4'h3, {21'h0, set, kind, mask}, d);
	endtask : trigger
	// no new trigger until no lane shows pending, else it is lost
	task automatic poll();
		logic [31:0] d;
		logic busy;
		busy = 1'b1;
		for (int r = 0; r < 64 && busy; r++) begin
			busy = 1'b0;
			for (int i = 0; i < 4; i++) begin
				xfer(1'b0, `IDX_RESULT_LANES_1_2 + 8'(i), 4'h1, 32'h0000_0000, d);
				busy |= d[7:4] == `OUTCOME_PENDING || d[3:0] == `OUTCOME_PENDING;
			end
		end
		if (busy) stalls++;
	endtask : poll
endmodule : host_ctrl_model
`default_nettype wire

/* File: lane_cfg_status_bench.sv */
// Purpose: self-checking bench for lane_cfg_status
// Assumes: host model speaks the bus, bench drives lane conditions
// Notes: short execute count keeps each command a few cycles long
`timescale 1ns/1ps
`default_nettype none
`include "lane_cfg_params.svh"
module lane_cfg_status_bench;
	import lane_cfg_pkg::*;
	logic         sys_clk = 1'b0;
	logic         sys_rst = 1'b1;
	wb_req_type   wb_req;
	logic         wb_ack_o;
	logic         mgmt_ready;
	logic         cmd_busy;
	logic [31:0]  wb_dat_o;
	lane_env_type env = '{8'hff, 8'h00, 8'hff, 16'h000e, 1'b0};
	int mismatches = 0;
	int samples_checked = 0;
	always #20 sys_clk = ~sys_clk;
	lane_cfg_status #(.EXEC_CYCLES(8)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.wb_req(wb_req), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .lane_env(env),
		.mgmt_ready(mgmt_ready), .cmd_busy(cmd_busy));
	host_ctrl_model host_u (.sys_clk(sys_clk), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		host_u.xfer(1'b0, idx, 4'hf, 32'h0000_0000, d);
		cmp(d, exp);
	endtask : rd
	task automatic wr(input logic [7:0] idx, input logic [31:0] v);
		logic [31:0] d;
		host_u.xfer(1'b1, idx, 4'hf, v, d);
	endtask : wr
	// lanes 1-4 all carry one code
	task automatic lanes_lo(input logic [3:0] c);
		rd(`IDX_RESULT_LANES_1_2, {24'h00_0000, c, c});
		rd(`IDX_RESULT_LANES_3_4, {24'h00_0000, c, c});
	endtask : lanes_lo
	// fresh device: blank status that ignores writes, default active set
	task automatic s_reset();
		wr(`IDX_RESULT_LANES_1_2, 32'h0000_00ff);
		for (int i = 0; i < 4; i++) rd(`IDX_RESULT_LANES_1_2 + 8'(i), 0);
		rd(`IDX_ACTIVE_TX_LO, 32'h1010_1010);
		rd(`IDX_ACTIVE_RX_HI, 32'h1010_1010);
		rd(8'h40, 32'h0000_0000);
		rd(`IDX_TRIGGER, 32'h0000_0000);
		#1 cmp({31'h0, mgmt_ready}, 32'h1);
	endtask : s_reset
	// a retrigger while pending must vanish without a trace
	task automatic s_success();
		wr(`IDX_STAGED0_LO, 32'h2020_2020);
		wr(`IDX_STAGED0_HI, 32'h3838_3838);
		host_u.trigger(8'h0f, `KIND_PATH_INIT, 1'b0);
		#1 cmp({31'h0, cmd_busy}, 32'h1);
		host_u.trigger(8'h0f, `KIND_IMM_TX, 1'b0);
		rd(`IDX_RESULT_LANES_1_2, 32'h0000_00cc);
		host_u.poll();
		lanes_lo(`OUTCOME_OK);
		#1 cmp({31'h0, cmd_busy}, 32'h0);
		rd(`IDX_ACTIVE_TX_LO, 32'h2020_2020);
	endtask : s_success
	// every failure gives its code and leaves the active set alone
	task automatic s_rejects();
		logic [31:0] w [6] = '{32'h2020_2020, 32'h2020_2020, 32'h4040_4040,
			32'h2222_2222, 32'h2121_2121, 32'h2020_2020};
		logic [7:0] m [6] = '{8'h0f, 8'h01, 8'h0f, 8'h0f, 8'h0f, 8'h0f};
		logic [3:0] c [6] = '{`REJECT_GENERIC, `REJECT_PARTIAL, `REJECT_BAD_APP,
			`REJECT_BAD_LANES, `REJECT_BAD_SI, `REJECT_LANES_BUSY};
		for (int i = 0; i < 6; i++) begin
			wr(`IDX_STAGED0_LO, w[i]);
			env.si_ok <= (i == 4) ? 8'h00 : 8'hff;
			env.path_off <= (i == 5) ? 8'hf0 : 8'hff;
			host_u.trigger(m[i], (i == 0) ? `KIND_IMM_TX : `KIND_PATH_INIT, 1'b0);
			host_u.poll();
			lanes_lo(c[i]);
			rd(`IDX_ACTIVE_TX_LO, 32'h2020_2020);
		end
		env.path_off <= 8'hff;
		env.si_ok <= 8'hff;
	endtask : s_rejects
	// two paths accepted back to back are both served
	task automatic s_parallel();
		wr(`IDX_STAGED0_LO, 32'h2020_2020);
		host_u.trigger(8'hf0, `KIND_PATH_INIT, 1'b0);
		host_u.trigger(8'h0f, `KIND_PATH_INIT, 1'b0);
		rd(`IDX_RESULT_LANES_1_2, 32'h0000_00cc);
		host_u.poll();
		rd(`IDX_RESULT_LANES_7_8, 32'h0000_0011);
		lanes_lo(`OUTCOME_OK);
		rd(`IDX_ACTIVE_TX_HI, 32'h3838_3838);
	endtask : s_parallel
	// rx alone on one live lane, then tx from set 1
	task automatic s_unidir();
		env.one_direction_reconf_capable <= 1'b1;
		env.path_live <= 8'hf0;
		wr(`IDX_STAGED1_HI, 32'h2828_2828);
		host_u.trigger(8'h10, `KIND_IMM_RX, 1'b1);
		rd(`IDX_RESULT_LANES_5_6, 32'h0000_001c);
		host_u.poll();
		rd(`IDX_ACTIVE_RX_HI, 32'h3838_3828);
		rd(`IDX_ACTIVE_TX_HI, 32'h3838_3838);
		host_u.trigger(8'hf0, `KIND_IMM_TX, 1'b1);
		host_u.poll();
		rd(`IDX_ACTIVE_TX_HI, 32'h2828_2828);
		rd(`IDX_RESULT_LANES_7_8, 32'h0000_0011);
	endtask : s_unidir
	task automatic close_out();
		mismatches += host_u.stalls;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	initial begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		s_reset();
		s_success();
		s_rejects();
		s_parallel();
		s_unidir();
		close_out();
	end
endmodule : lane_cfg_status_bench
`default_nettype wire
